/* src/display_refresh_regs.vh */
// Purpose: Register map, field positions and reset values
// Assumes: 12-bit words on a 4-bit word index
// Notes:   Definitions only
`ifndef DISPLAY_REFRESH_REGS_VH
`define DISPLAY_REFRESH_REGS_VH

// Register word indices
`define REG_XPIX 4'h0
`define REG_YPIX 4'h1
`define REG_PAN 4'h2
`define REG_SCROLL 4'h3
`define REG_YZOOM 4'h4
`define REG_CONTROL 4'h5
`define REG_COMMAND 4'h6
`define REG_STATUS 4'h7
`define REG_REFRESH_ADDR 4'h8

// Control register fields
`define CTRL_DEPTH_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_XZOOM_LSB 3

// Command register fields
`define CMD_ERASE0_BIT 0
`define CMD_ERASE1_BIT 1

// Status register fields
`define STAT_ERASE_ACTIVE_BIT 0
`define STAT_ERASE_PEND_LSB 1
`define STAT_CLIP_BIT 3

// Resolution modes
`define MODE_640X256 2'h0
`define MODE_1280X256 2'h1
`define MODE_640X512 2'h2

// X zoom codes
`define XZOOM_1 2'h0
`define XZOOM_2 2'h1
`define XZOOM_4 2'h2

// Physical memory limits
`define LIMIT_X_NARROW 12'h280
`define LIMIT_X_WIDE 12'h500
`define LIMIT_Y_SHORT 12'h100
`define LIMIT_Y_TALL 12'h200

// Pixels per memory block
`define PIXELS_PER_BLOCK 12'h00a

// Reset values
`define RESET_REG12 12'h000
`define RESET_REG10 10'h000

`endif

/* src/pixel_counter.v */
// Purpose: Loadable up/down pixel coordinate counter
// Assumes: Active-low steps, synchronous to sys_clk
// Notes:   A load wins over a step in the same cycle
`timescale 1ns/1ps

module pixel_counter #(
    parameter WIDTH = 12
) (
    input wire sys_clk,
    input wire rst_b,
    input wire load,
    input wire [WIDTH-1:0] loadValue,
    input wire stepUpN,
    input wire stepDownN,
    output reg [WIDTH-1:0] count_q
);

    // Load beats steps; two steps at once cancel
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            count_q <= {WIDTH{1'b0}};
        end else if (load) begin
            count_q <= loadValue;
        end else if (!stepUpN && stepDownN) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (stepUpN && !stepDownN) begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // pixel_counter

/* src/display_refresh_addr_gen.v */
// Purpose: Refresh counters, address mux, plane strobes, erase and pixel registers
// Assumes: Timing inputs synchronous to sys_clk
//          and sampled as levels
// Notes:   Registered outputs lag their inputs by one clock
`timescale 1ns/1ps
`include "display_refresh_regs.vh"

////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Owner high selects refresh, low CPU
// - Row half while RAS high, column low
// - CPU column: X4-X8, Y0, Y1
// - CPU row: Y2-Y5, X9, Y6, Y7
// - Refresh column: RX4-RX8, RY0, RY1
// - Refresh row: RY2-RY5, RX9, RY6, RY7
// - Low refresh bits form RAM row
// - Refresh X7, X8 XORed with zoom selects
// - Zoom4 both toggle; zoom2 sel0 toggles, sel1 held high
// - X counter loads pan, counts shift clock
// - Pan steps move image ten pixels
// - Y counter loads scroll at vertical start
// - Y advances every N line pulses
// - Strobe mux gated by CAS, owner, depth
// - Strobe sources per owner and depth
// - Command write latches two erase requests
// - Next scan: inverted masks, writes forced
// - Scan end clears erase logic
// - Pixel registers are 12-bit up/down counters
// - Pixel address translated per resolution mode
// - Out-of-bounds blocks memory access
// - Shift clock advances the refresh X counter
module display_refresh_addr_gen #(
    parameter DATA_WIDTH = 12,
    parameter REFRESH_WIDTH = 10
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [3:0] regAddr,
    input wire [DATA_WIDTH-1:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [DATA_WIDTH-1:0] regReadData,
    input wire cycleOwnerN,
    input wire rasN,
    input wire casN,
    input wire refreshShiftClkN,
    input wire panLoadN,
    input wire hlinePulse,
    input wire vblank,
    input wire xStepUpN,
    input wire xStepDownN,
    input wire yStepUpN,
    input wire yStepDownN,
    output reg [6:0] memAddrLines,
    output reg plane0ColStrobeN,
    output reg plane1ColStrobeN,
    output reg eraseWriteForce,
    output reg clipN
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Translation helpers

    // X lookup: {page, block, pixel in block}
    function [10:0] xlate_x;
        input [11:0] x;
        input [1:0] mode;
        reg [11:0] xx;
        reg [11:0] blk;
        reg [11:0] rem;
        begin
            xx = (mode == `MODE_1280X256) ? {1'b0, x[11:1]} : x;
            blk = xx / `PIXELS_PER_BLOCK;
            rem = xx - blk * `PIXELS_PER_BLOCK;
            xlate_x = {(mode == `MODE_1280X256) & x[0], blk[5:0], rem[3:0]};
        end
    endfunction

    // Y mux: interlaced mode uses the low bit as page
    function [8:0] xlate_y;
        input [11:0] y;
        input [1:0] mode;
        begin
            if (mode == `MODE_640X512) begin
                xlate_y = {y[0], y[8:1]};
            end else begin
                xlate_y = {1'b0, y[7:0]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Software-written registers

    reg [REFRESH_WIDTH-1:0] pan_q; // Coarse pan start value
    reg [REFRESH_WIDTH-1:0] scroll_q; // Vertical scroll start value
    reg [2:0] yZoom_q; // Y zoom factor minus one
    reg planeDepthSel_q; // 0 one plane, 1 two planes
    reg [1:0] resMode_q; // Resolution arrangement
    reg [1:0] xZoom_q; // X zoom code
    wire xLoad; // CPU load of X pixel register
    wire yLoad; // CPU load of Y pixel register

    assign xLoad = regWrite && (regAddr == `REG_XPIX);
    assign yLoad = regWrite && (regAddr == `REG_YPIX);

    // Register writes; unmapped writes are dropped
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            pan_q <= `RESET_REG10;
            scroll_q <= `RESET_REG10;
            yZoom_q <= 3'h0;
            planeDepthSel_q <= 1'b0;
            resMode_q <= `MODE_640X256;
            xZoom_q <= `XZOOM_1;
        end else if (regWrite) begin
            case (regAddr)
                `REG_PAN: begin
                    pan_q <= regWriteData[REFRESH_WIDTH-1:0];
                end
                `REG_SCROLL: begin
                    scroll_q <= regWriteData[REFRESH_WIDTH-1:0];
                end
                `REG_YZOOM: begin
                    yZoom_q <= regWriteData[2:0];
                end
                `REG_CONTROL: begin
                    planeDepthSel_q <= regWriteData[`CTRL_DEPTH_BIT];
                    resMode_q <= regWriteData[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
                    xZoom_q <= regWriteData[`CTRL_XZOOM_LSB+1:`CTRL_XZOOM_LSB];
                end
                default: begin
                    // No plain storage
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pixel registers

    wire [11:0] xPix; // X pixel register value
    wire [11:0] yPix; // Y pixel register value

    // Vector unit steps, CPU loads
    pixel_counter #(.WIDTH(12)) xCounter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load(xLoad),
        .loadValue(regWriteData[11:0]),
        .stepUpN(xStepUpN),
        .stepDownN(xStepDownN),
        .count_q(xPix)
    );

    pixel_counter #(.WIDTH(12)) yCounter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load(yLoad),
        .loadValue(regWriteData[11:0]),
        .stepUpN(yStepUpN),
        .stepDownN(yStepDownN),
        .count_q(yPix)
    );

    wire [10:0] xTrans; // {page, xpix_bit[9:0]}
    wire [8:0] yTrans; // {page, ypix_bit[7:0]}
    wire [9:0] xpixBit; // Translated X address
    wire [7:0] ypixBit; // Translated Y address
    wire pixelPage; // Plane holding the addressed pixel
    wire [11:0] xLimit; // Physical width for the mode
    wire [11:0] yLimit; // Physical height for the mode
    wire outOfBounds; // Inside working area, outside memory

    assign xTrans = xlate_x(xPix, resMode_q);
    assign yTrans = xlate_y(yPix, resMode_q);
    assign xpixBit = xTrans[9:0];
    assign ypixBit = yTrans[7:0];
    assign pixelPage = xTrans[10] | yTrans[8];
    assign xLimit = (resMode_q == `MODE_1280X256) ? `LIMIT_X_WIDE : `LIMIT_X_NARROW;
    assign yLimit = (resMode_q == `MODE_640X512) ? `LIMIT_Y_TALL : `LIMIT_Y_SHORT;
    // 12-bit values stay in the working area; only memory bounds matter
    assign outOfBounds = (xPix >= xLimit) || (yPix >= yLimit);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Refresh timing edges and zoom selects

    reg vblank_q; // Previous vertical blanking level
    wire scanStart; // Blanking ends: vertical scan begins
    wire scanEnd; // Blanking begins: vertical scan over

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            vblank_q <= 1'b0;
        end else begin
            vblank_q <= vblank;
        end
    end

    assign scanStart = vblank_q && !vblank;
    assign scanEnd = !vblank_q && vblank;

    reg [1:0] lineToggle_q; // Per-line phase for the refresh-only rows
    reg zoomRefreshSel0; // Flips raw X bit 7
    reg zoomRefreshSel1; // Flips raw X bit 8

    // Line phase; its bits walk the hidden rows line by line
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            lineToggle_q <= 2'h0;
        end else if (hlinePulse) begin
            lineToggle_q <= lineToggle_q + 2'h1;
        end
    end

    // Zoom selects per X zoom factor
    always @* begin
        zoomRefreshSel0 = 1'b0;
        zoomRefreshSel1 = 1'b0;
        case (xZoom_q)
            `XZOOM_2: begin
                zoomRefreshSel0 = lineToggle_q[0];
                zoomRefreshSel1 = 1'b1;
            end
            `XZOOM_4: begin
                zoomRefreshSel0 = lineToggle_q[0];
                zoomRefreshSel1 = lineToggle_q[1];
            end
            default: begin
                // Zoom by one sweeps every row on its own
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Refresh counters

    reg [REFRESH_WIDTH-1:0] rawRefreshX_q; // X refresh counter
    reg [REFRESH_WIDTH-1:0] refreshY_q; // Y refresh counter
    reg [2:0] lineDiv_q; // Line pulses since last Y step

    // X counter: pan load wins over a shift clock in the same cycle
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            rawRefreshX_q <= `RESET_REG10;
        end else if (!panLoadN) begin
            rawRefreshX_q <= pan_q;
        end else if (!refreshShiftClkN) begin
            rawRefreshX_q <= rawRefreshX_q + 10'h001;
        end
    end

    // Y counter: scroll loaded through blanking, then one step every N lines
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            refreshY_q <= `RESET_REG10;
            lineDiv_q <= 3'h0;
        end else if (vblank) begin
            refreshY_q <= scroll_q;
            lineDiv_q <= 3'h0;
        end else if (hlinePulse) begin
            if (lineDiv_q >= yZoom_q) begin
                refreshY_q <= refreshY_q + 10'h001;
                lineDiv_q <= 3'h0;
            end else begin
                lineDiv_q <= lineDiv_q + 3'h1;
            end
        end
    end

    wire [REFRESH_WIDTH-1:0] refreshXBit; // X refresh address after zoom fix
    wire rawRefreshXBit7; // Counter bit 7 before the XOR
    wire rawRefreshXBit8; // Counter bit 8 before the XOR

    assign rawRefreshXBit7 = rawRefreshX_q[7];
    assign rawRefreshXBit8 = rawRefreshX_q[8];
    assign refreshXBit = {rawRefreshX_q[9],
                          rawRefreshXBit8 ^ zoomRefreshSel1,
                          rawRefreshXBit7 ^ zoomRefreshSel0,
                          rawRefreshX_q[6:0]};

    ////////////////////////////////////////////////////////////////////////////////////////
    // Memory address multiplexer

    reg [6:0] memAddr_d; // Next address on the memory lines

    // Owner picks the source, RAS picks the half
    always @* begin
        case ({cycleOwnerN, rasN})
            2'b00: begin
                memAddr_d = {ypixBit[1:0], xpixBit[8:4]};
            end
            2'b01: begin
                memAddr_d = {ypixBit[7:6], xpixBit[9], ypixBit[5:2]};
            end
            2'b10: begin
                // Low bits sweep every RAM row in time
                memAddr_d = {refreshY_q[1:0], refreshXBit[8:4]};
            end
            2'b11: begin
                memAddr_d = {refreshY_q[7:6], refreshXBit[9], refreshY_q[5:2]};
            end
            default: begin
                memAddr_d = 7'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Erase logic

    reg [1:0] eraseReq_q; // Requested planes
    reg eraseActive_q; // Erase running for this scan
    reg eraseMask0_q; // Refresh strobe source, plane 0
    reg eraseMask1_q; // Refresh strobe source, plane 1
    wire cmdWrite; // Command register write

    assign cmdWrite = regWrite && (regAddr == `REG_COMMAND);

    // Request, arm at scan start, clear at scan end; a new command beats the clear.
    // Data contents during the erase are firmware's job: it loads zero first.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            eraseReq_q <= 2'h0;
            eraseActive_q <= 1'b0;
            eraseMask0_q <= 1'b0;
            eraseMask1_q <= 1'b0;
        end else begin
            if (cmdWrite) begin
                eraseReq_q <= {regWriteData[`CMD_ERASE1_BIT],
                               regWriteData[`CMD_ERASE0_BIT]};
            end else if (scanEnd && eraseActive_q) begin
                eraseReq_q <= 2'h0;
            end
            if (scanStart && (eraseReq_q != 2'h0)) begin
                eraseActive_q <= 1'b1;
                eraseMask0_q <= ~eraseReq_q[0];
                eraseMask1_q <= ~eraseReq_q[1];
            end else if (scanEnd) begin
                eraseActive_q <= 1'b0;
                eraseMask0_q <= 1'b0;
                eraseMask1_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Plane strobe multiplexer

    reg plane0Strobe_d; // Next plane 0 strobe, active low
    reg plane1Strobe_d; // Next plane 1 strobe, active low

    // Strobes idle high while CAS is high or a CPU access is clipped
    always @* begin
        plane0Strobe_d = 1'b1;
        plane1Strobe_d = 1'b1;
        if (!casN) begin
            case ({cycleOwnerN, planeDepthSel_q})
                2'b00: begin
                    plane0Strobe_d = pixelPage;
                    plane1Strobe_d = ~pixelPage;
                end
                2'b01: begin
                    plane0Strobe_d = 1'b0;
                    plane1Strobe_d = 1'b0;
                end
                2'b10: begin
                    plane0Strobe_d = eraseMask0_q;
                    plane1Strobe_d = eraseMask0_q;
                end
                2'b11: begin
                    plane0Strobe_d = eraseMask0_q;
                    plane1Strobe_d = eraseMask1_q;
                end
                default: begin
                    plane0Strobe_d = 1'b1;
                    plane1Strobe_d = 1'b1;
                end
            endcase
            if (!cycleOwnerN && outOfBounds) begin
                plane0Strobe_d = 1'b1;
                plane1Strobe_d = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            memAddrLines <= 7'h00;
            plane0ColStrobeN <= 1'b1;
            plane1ColStrobeN <= 1'b1;
            eraseWriteForce <= 1'b0;
            clipN <= 1'b1;
        end else begin
            memAddrLines <= memAddr_d;
            plane0ColStrobeN <= plane0Strobe_d;
            plane1ColStrobeN <= plane1Strobe_d;
            eraseWriteForce <= eraseActive_q;
            clipN <= ~outOfBounds;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register read port

    // Data stand one cycle after the strobe; zero otherwise or unmapped
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            regReadData <= `RESET_REG12;
        end else if (regRead) begin
            case (regAddr)
                `REG_XPIX: regReadData <= xPix;
                `REG_YPIX: regReadData <= yPix;
                `REG_PAN: regReadData <= {2'h0, pan_q};
                `REG_SCROLL: regReadData <= {2'h0, scroll_q};
                `REG_YZOOM: regReadData <= {9'h000, yZoom_q};
                `REG_CONTROL: regReadData <= {7'h00, xZoom_q, resMode_q, planeDepthSel_q};
                `REG_COMMAND: regReadData <= {10'h000, eraseReq_q};
                `REG_STATUS: regReadData <= {8'h00, outOfBounds, eraseReq_q, eraseActive_q};
                `REG_REFRESH_ADDR: regReadData <= {2'h0, refreshXBit};
                default: regReadData <= `RESET_REG12;
            endcase
        end else begin
            regReadData <= `RESET_REG12;
        end
    end

endmodule // display_refresh_addr_gen

/* tb/dram_model.sv */
// Purpose: Display memory stand-in latching row and column halves
// Assumes: Address lags the row/column select by one clock
// Notes:   No data storage
`timescale 1ns/1ps
module dram_model (
    input wire sys_clk,
    input wire rasN,
    input wire [6:0] memAddrLines,
    output reg [6:0] rowQ,
    output reg [6:0] colQ
);
    reg rasSeen_q; // Select delayed to line up with the registered address
    ////////////////////////////////////////////////////////////////////////
    // Latch each half by the select that produced it
    always @(posedge sys_clk) begin
        rasSeen_q <= rasN;
        if (rasSeen_q) begin
            rowQ <= memAddrLines;
        end else begin
            colQ <= memAddrLines;
        end
    end
endmodule // dram_model

/* tb/display_refresh_addr_gen_props.sv */
// Purpose: Port checks on strobes, erase, read data, address holds
// Assumes: One clock, synchronous low reset
// Notes:   Bound into the top module
`timescale 1ns/1ps
module display_refresh_props #(
    parameter DATA_WIDTH = 12
) (
    input wire sys_clk,
    input wire rst_b,
    input wire regWrite,
    input wire regRead,
    input wire [DATA_WIDTH-1:0] regReadData,
    input wire cycleOwnerN,
    input wire rasN,
    input wire casN,
    input wire refreshShiftClkN,
    input wire panLoadN,
    input wire hlinePulse,
    input wire vblank,
    input wire xStepUpN,
    input wire xStepDownN,
    input wire yStepUpN,
    input wire yStepDownN,
    input wire [6:0] memAddrLines,
    input wire plane0ColStrobeN,
    input wire plane1ColStrobeN,
    input wire eraseWriteForce,
    input wire clipN
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire stepsIdle = xStepUpN && xStepDownN && yStepUpN && yStepDownN; // No pixel steps
    ////////////////////////////////////////////////////////////////////////
    a_cas_gates: assert property (casN |=> plane0ColStrobeN && plane1ColStrobeN)
        else $error("strobe without CAS");
    a_clip_blocks: assert property (!cycleOwnerN ##1 !clipN |-> plane0ColStrobeN && plane1ColStrobeN)
        else $error("clipped access strobed");
    a_refresh_idle: assert property (cycleOwnerN && !casN ##1 !eraseWriteForce
        |-> !plane0ColStrobeN && !plane1ColStrobeN)
        else $error("refresh strobe off");
    a_erase_start: assert property ($rose(eraseWriteForce)
        |-> !$past(vblank) && ($past(vblank, 2) || $past(vblank, 3)))
        else $error("force rose late");
    a_erase_end: assert property ($fell(eraseWriteForce) |-> $past(vblank))
        else $error("force fell early");
    a_blank_clears: assert property (vblank [*4] |-> !eraseWriteForce)
        else $error("force held in blank");
    a_read_idle: assert property (!$past(regRead) |-> regReadData == 12'h000)
        else $error("stray read data");
    a_refresh_hold: assert property ((cycleOwnerN && rasN && refreshShiftClkN && panLoadN
        && !hlinePulse && !vblank) [*3] |=> $stable(memAddrLines))
        else $error("refresh row moved");
    a_cpu_hold: assert property ((!cycleOwnerN && !rasN && !regWrite && stepsIdle) [*3]
        |=> $stable(memAddrLines))
        else $error("cpu column moved");
    c_erase: cover property ($rose(eraseWriteForce));
    c_clip: cover property ($fell(clipN));
    c_read: cover property (regRead);
endmodule // display_refresh_props
bind display_refresh_addr_gen display_refresh_props #(.DATA_WIDTH(DATA_WIDTH)) i_props (.*);

/* tb/display_refresh_addr_gen_test.sv */
// Purpose: Self-checking bench for the address generator
// Assumes: Outputs lag inputs one clock; drives follow rising edges
// Notes:   Expected values from bench arithmetic
`timescale 1ns/1ps
`include "display_refresh_regs.vh"
module display_refresh_addr_gen_test;
    reg sys_clk, rst_b, regWrite, regRead, cycleOwnerN, rasN, casN, refreshShiftClkN;
    reg panLoadN, hlinePulse, vblank, xUpN, xDnN, yUpN, yDnN;
    reg [3:0] regAddr;
    reg [11:0] regWriteData, x, y, d, s, p, xb, rx;
    reg [31:0] seed; // Xorshift state
    wire [11:0] regReadData;
    wire [6:0] memAddrLines, rowQ, colQ;
    wire p0N, p1N, eraseWriteForce, clipN;
    integer fails, n_tests, i;
    display_refresh_addr_gen i_display_refresh_addr_gen (.sys_clk(sys_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .cycleOwnerN(cycleOwnerN), .rasN(rasN), .casN(casN),
        .refreshShiftClkN(refreshShiftClkN), .panLoadN(panLoadN), .hlinePulse(hlinePulse),
        .vblank(vblank), .xStepUpN(xUpN), .xStepDownN(xDnN), .yStepUpN(yUpN), .yStepDownN(yDnN),
        .memAddrLines(memAddrLines), .plane0ColStrobeN(p0N), .plane1ColStrobeN(p1N),
        .eraseWriteForce(eraseWriteForce), .clipN(clipN));
    dram_model i_dram_model (.sys_clk(sys_clk), .rasN(rasN), .memAddrLines(memAddrLines),
        .rowQ(rowQ), .colQ(colQ));
    ////////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input [8*8:1] nm, input [11:0] seen, input [11:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Tasks open on an edge: no double drive
    task wr(input [3:0] a, input [11:0] v);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regWriteData <= v;
            regWrite <= 1'b1;
            @(posedge sys_clk);
            regWrite <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [11:0] v);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge sys_clk);
            regRead <= 1'b0;
            #1 v = regReadData;
        end
    endtask
    // Hold a cycle kind until the model latches it
    task mem(input o, input r, input c);
        begin
            @(posedge sys_clk);
            cycleOwnerN <= o;
            rasN <= r;
            casN <= c;
            repeat (3) @(posedge sys_clk);
            #1;
        end
    endtask
    task vb(input v);
        begin
            @(posedge sys_clk);
            vblank <= v;
            repeat (5) @(posedge sys_clk);
            #1;
        end
    endtask
    task hl;
        begin
            @(posedge sys_clk);
            hlinePulse <= 1'b1;
            @(posedge sys_clk);
            hlinePulse <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails = fails + 1;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {regWrite, regRead, hlinePulse, vblank} = 4'h0;
        {cycleOwnerN, rasN, casN, refreshShiftClkN, panLoadN, xUpN, xDnN, yUpN, yDnN} = 9'h1ff;
        regAddr = 4'h0;
        regWriteData = 12'h000;
        rst_b = 1'b0;
        fails = 0;
        n_tests = 0;
        seed = 32'hf7ff;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 chk("rstout", {4'h0, memAddrLines, eraseWriteForce}, 12'h000);
        chk("rststb", {9'h0, p1N, p0N, clipN}, 12'h007);
        for (i = 0; i < 4; i = i + 1) begin // Random in-bounds pixel positions
            seed = xs(seed);
            x = seed % 640;
            seed = xs(seed);
            y = seed % 256;
            wr(`REG_XPIX, x);
            wr(`REG_YPIX, y);
            rd(`REG_XPIX, d); chk("xpix", d, x);
            rd(`REG_YPIX, d); chk("ypix", d, y);
            xb = ((x / 10) << 4) | (x % 10);
            mem(1'b0, 1'b0, 1'b0); chk("cpucol", {5'h0, colQ}, {5'h0, y[1:0], xb[8:4]});
            chk("cpustb", {10'h0, p1N, p0N}, 12'h002);
            mem(1'b0, 1'b1, 1'b0); chk("cpurow", {5'h0, rowQ}, {5'h0, y[7:6], xb[9], y[5:2]});
        end
        rd(4'hf, d); chk("unmapped", d, 12'h000);
        wr(`REG_CONTROL, 12'h001);
        mem(1'b0, 1'b0, 1'b0); chk("cpu2pl", {10'h0, p1N, p0N}, 12'h000);
        mem(1'b0, 1'b0, 1'b1); chk("casoff", {10'h0, p1N, p0N}, 12'h003);
        wr(`REG_XPIX, 12'h280);
        mem(1'b0, 1'b0, 1'b0); chk("clip", {9'h0, p1N, p0N, clipN}, 12'h006);
        // X: three up, one down; Y: one down
        wr(`REG_XPIX, x);
        @(posedge sys_clk); xUpN <= 1'b0; yDnN <= 1'b0;
        @(posedge sys_clk); yDnN <= 1'b1;
        repeat (2) @(posedge sys_clk); xUpN <= 1'b1; xDnN <= 1'b0;
        @(posedge sys_clk); xDnN <= 1'b1;
        rd(`REG_XPIX, d); chk("xstep", d, x + 12'h002);
        rd(`REG_YPIX, d); chk("ystep", d, y - 12'h001);
        $display("test pixel and cpu mux done");
        seed = xs(seed);
        p = seed & 12'h1ff;
        s = seed[23:12] & 12'hfe;
        rx = p + 12'h005;
        wr(`REG_PAN, p);
        wr(`REG_SCROLL, s);
        @(posedge sys_clk); panLoadN <= 1'b0;
        @(posedge sys_clk); panLoadN <= 1'b1; refreshShiftClkN <= 1'b0;
        repeat (5) @(posedge sys_clk); refreshShiftClkN <= 1'b1;
        rd(`REG_REFRESH_ADDR, d); chk("refx", d, rx);
        vb(1'b1);
        vb(1'b0);
        mem(1'b1, 1'b0, 1'b0); chk("refcol", {5'h0, colQ}, {5'h0, s[1:0], rx[8:4]});
        chk("refstb", {10'h0, p1N, p0N}, 12'h000);
        mem(1'b1, 1'b1, 1'b0); chk("refrow", {5'h0, rowQ}, {5'h0, s[7:6], rx[9], s[5:2]});
        wr(`REG_YZOOM, 12'h002);
        vb(1'b1);
        vb(1'b0);
        hl;
        hl;
        mem(1'b1, 1'b1, 1'b0); chk("yzoom2", {5'h0, rowQ}, {5'h0, s[7:6], rx[9], s[5:2]});
        hl;
        s = s + 12'h001;
        mem(1'b1, 1'b1, 1'b0); chk("yzoom3", {5'h0, rowQ}, {5'h0, s[7:6], rx[9], s[5:2]});
        wr(`REG_CONTROL, 12'h008);
        rd(`REG_REFRESH_ADDR, d); chk("xzoom2", {11'h0, d[8]}, {11'h0, ~rx[8]});
        $display("test refresh counters done");
        wr(`REG_CONTROL, 12'h001);
        for (i = 1; i < 4; i = i + 1) begin // Erase plane 0, 1, both; force and strobes checked
            wr(`REG_COMMAND, i);
            vb(1'b1);
            vb(1'b0);
            chk("ersforce", {11'h0, eraseWriteForce}, 12'h001);
            mem(1'b1, 1'b0, 1'b0); chk("ersstb", {10'h0, p1N, p0N}, ~i & 12'h003);
            vb(1'b1);
            chk("ersdone", {11'h0, eraseWriteForce}, 12'h000);
            mem(1'b1, 1'b0, 1'b0); chk("ersidle", {10'h0, p1N, p0N}, 12'h000);
        end
        $display("test erase done");
        report_and_stop;
    end
endmodule // display_refresh_addr_gen_test
